// ---- shared/radio_status_map.svh ----
// Offsets, field positions and reset values of the radio status registers.
// Assumes the serial port logic hands over a 6-bit register address.
`ifndef RADIO_STATUS_MAP_SVH
`define RADIO_STATUS_MAP_SVH

`define ADDR_W 6
`define DATA_W 8
`define STATE_W 5

`define OFFSET_CARRIER_OFFSET_ESTIMATE 6'h32
`define OFFSET_CRC_RESULT_STATUS 6'h33
`define OFFSET_SIGNAL_STRENGTH 6'h34
`define OFFSET_RADIO_FSM_STATE 6'h35

`define CRC_PASS_BIT 7
`define STATE_CODE_MSB 4
`define STATE_CODE_LSB 0

`define RESET_OFFSET_ESTIMATE 8'h00
`define RESET_SIGNAL_STRENGTH 8'h00
`define RESET_STATE_CODE 5'h01
`define UNMAPPED_READ_VALUE 8'h00
`define HIGHEST_STATE_CODE 5'h16

`endif

// ---- shared/radio_status_pkg.sv ----
// Types shared by the radio status read-back logic.
// Assumes nothing of its surroundings.
`default_nettype none
package radio_status_pkg;

	typedef enum logic [4:0] {
		sleep_state = 5'h00,
		idle_state = 5'h01,
		crystal_off_state = 5'h02,
		manual_cal_osc_on_state = 5'h03,
		manual_cal_regulator_on_state = 5'h04,
		manual_calibration_state = 5'h05,
		wakeup_osc_on_state = 5'h06,
		wakeup_regulator_on_state = 5'h07,
		calibration_begin_state = 5'h08,
		bandwidth_boost_state = 5'h09,
		synth_lock_state = 5'h0A,
		if_converter_on_state = 5'h0B,
		calibration_finish_state = 5'h0C,
		receiving_state = 5'h0D,
		receive_end_state = 5'h0E,
		receive_restart_state = 5'h0F,
		tx_to_rx_turnaround_state = 5'h10,
		receive_buffer_overflow_state = 5'h11,
		synth_ready_for_tx_state = 5'h12,
		transmitting_state = 5'h13,
		transmit_end_state = 5'h14,
		rx_to_tx_turnaround_state = 5'h15,
		transmit_buffer_underflow_state = 5'h16
	} radio_state_e;

	typedef enum logic [1:0] {
		mod_2fsk = 2'h0,
		mod_gfsk = 2'h1,
		mod_ook = 2'h2,
		mod_4fsk = 2'h3
	} modulation_e;

endpackage
`default_nettype wire

// ---- design/radio_status_readback.sv ----
// Read-only status register group of the transceiver: carrier offset
// estimate, last CRC result, signal strength and radio control state.
// Assumes the serial configuration port logic presents decoded register
// accesses on core_clk, and that the demodulator, packet handler and
// radio control state machine drive their inputs synchronously.
`include "radio_status_map.svh"
`timescale 1ns/1ps
`default_nettype none

// Contract
// [R1] Offset estimate is signed, step crystal/2^14
// [R2] Offset reads zero under on-off keying
// [R3] Bit 7 set on matching CRC
// [R4] CRC flag cleared entering or restarting receive; a check completing in the same cycle loads its result instead
// [R5] Eight-bit read-only signal strength register
// [R6] State code in bits 4:0, 7:5 zero
// [R7] Codes 0x00 sleep, 0x01 idle, 0x02 crystal-off
// [R8] Manual calibration codes 0x03, 0x04, 0x05
// [R9] Wake-up codes 0x06 and 0x07
// [R10] Calibration start 0x08, end 0x0C
// [R11] Settling codes 0x09, 0x0A, 0x0B
// [R12] Receive codes 0x0D, 0x0E, 0x0F
// [R13] Turnaround codes 0x10 and 0x15
// [R14] Overflow 0x11, underflow 0x16
// [R15] Transmit codes 0x12, 0x13, 0x14
// [R16] Chip select low wakes sleep or crystal-off
// [R17] Writes never change reported values
module radio_status_readback #(
	parameter int ADDR_W = `ADDR_W,
	parameter int DATA_W = `DATA_W,
	parameter int STATE_W = `STATE_W
) (
	input wire logic core_clk,
	input wire logic rst_b,
	// Decoded register access from the serial configuration port.
	input wire logic [ADDR_W-1:0] reg_addr,
	input wire logic reg_rd_en,
	input wire logic reg_wr_en,
	input wire logic [DATA_W-1:0] reg_wdata,
	output logic [DATA_W-1:0] reg_rdata,
	output logic reg_rd_valid,
	output logic reg_wr_ignored,
	// Demodulator.
	input wire logic [DATA_W-1:0] offset_estimate_field,
	input wire logic offset_estimate_valid,
	input wire logic [1:0] modulation_select,
	input wire logic [DATA_W-1:0] signal_strength_value,
	input wire logic signal_strength_valid,
	// Packet handler.
	input wire logic crc_check_done,
	input wire logic crc_check_match,
	// Radio control state machine.
	input wire logic [STATE_W-1:0] fsm_state_code,
	input wire logic rx_mode_enter,
	input wire logic rx_mode_restart,
	// Host chip select, active low, synchronous to core_clk.
	input wire logic chip_select_n,
	output logic wake_to_idle_req,
	output logic state_code_fault,
	output logic crc_pass
);

	// ----------------------------------------------------------------
	// Carrier offset estimate
	// ----------------------------------------------------------------

	logic [DATA_W-1:0] carrier_offset_estimate;
	logic ook_selected;

	assign ook_selected =
		(modulation_select == radio_status_pkg::mod_ook);

	// The estimate is held as raw two's complement; no scaling is done
	// here because one step already equals the crystal over 2^14.
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			carrier_offset_estimate <= `RESET_OFFSET_ESTIMATE;
		end else if (ook_selected) begin
			// [R2] zero under OOK
			carrier_offset_estimate <= `RESET_OFFSET_ESTIMATE;
		end else if (offset_estimate_valid) begin
			// [R1] store signed estimate
			carrier_offset_estimate <= offset_estimate_field;
		end
	end

	// ----------------------------------------------------------------
	// CRC result
	// ----------------------------------------------------------------

	logic crc_pass_flag;
	logic next_crc_pass_flag;

	// A completed check always replaces the flag, so a result arriving in
	// the same cycle as a receive entry is kept rather than lost.
	always_comb begin
		next_crc_pass_flag = crc_pass_flag;
		if (rx_mode_enter || rx_mode_restart) begin
			// [R4] clear on receive entry
			next_crc_pass_flag = 1'b0;
		end
		if (crc_check_done) begin
			// [R3] set on CRC match
			next_crc_pass_flag = crc_check_match;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			crc_pass_flag <= 1'b0;
		end else begin
			crc_pass_flag <= next_crc_pass_flag;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			crc_pass <= 1'b0;
		end else begin
			crc_pass <= next_crc_pass_flag;
		end
	end

	// ----------------------------------------------------------------
	// Signal strength
	// ----------------------------------------------------------------

	logic [DATA_W-1:0] signal_strength;

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			signal_strength <= `RESET_SIGNAL_STRENGTH;
		end else if (signal_strength_valid) begin
			// [R5] hold latest strength
			signal_strength <= signal_strength_value;
		end
	end

	// ----------------------------------------------------------------
	// Radio control state code
	// ----------------------------------------------------------------

	logic [STATE_W-1:0] radio_fsm_state;
	logic code_known;

	// Only documented codes are reported. An undefined code from the
	// state machine keeps the last good one, so the host never sees a
	// value that has no meaning, at the cost of hiding the glitch unless
	// the fault output is watched.
	always_comb begin
		case (fsm_state_code)
			// [R7] sleep idle crystal-off
			radio_status_pkg::sleep_state,
			radio_status_pkg::idle_state,
			radio_status_pkg::crystal_off_state: begin
				code_known = 1'b1;
			end
			// [R8] manual calibration steps
			radio_status_pkg::manual_cal_osc_on_state,
			radio_status_pkg::manual_cal_regulator_on_state,
			radio_status_pkg::manual_calibration_state: begin
				code_known = 1'b1;
			end
			// [R9] synthesizer wake-up
			radio_status_pkg::wakeup_osc_on_state,
			radio_status_pkg::wakeup_regulator_on_state: begin
				code_known = 1'b1;
			end
			// [R10] calibration start, end
			radio_status_pkg::calibration_begin_state,
			radio_status_pkg::calibration_finish_state: begin
				code_known = 1'b1;
			end
			// [R11] synthesizer settling
			radio_status_pkg::bandwidth_boost_state,
			radio_status_pkg::synth_lock_state,
			radio_status_pkg::if_converter_on_state: begin
				code_known = 1'b1;
			end
			// [R12] receive phases
			radio_status_pkg::receiving_state,
			radio_status_pkg::receive_end_state,
			radio_status_pkg::receive_restart_state: begin
				code_known = 1'b1;
			end
			// [R13] turnaround settling
			radio_status_pkg::tx_to_rx_turnaround_state,
			radio_status_pkg::rx_to_tx_turnaround_state: begin
				code_known = 1'b1;
			end
			// [R14] buffer fault states
			radio_status_pkg::receive_buffer_overflow_state,
			radio_status_pkg::transmit_buffer_underflow_state: begin
				code_known = 1'b1;
			end
			// [R15] transmit phases
			radio_status_pkg::synth_ready_for_tx_state,
			radio_status_pkg::transmitting_state,
			radio_status_pkg::transmit_end_state: begin
				code_known = 1'b1;
			end
			default: begin
				code_known = 1'b0;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			radio_fsm_state <= `RESET_STATE_CODE;
		end else if (code_known) begin
			radio_fsm_state <= fsm_state_code;
		end
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			state_code_fault <= 1'b0;
		end else begin
			state_code_fault <= !code_known;
		end
	end

	// ----------------------------------------------------------------
	// Wake on chip select
	// ----------------------------------------------------------------

	logic reported_asleep;

	assign reported_asleep =
		(radio_fsm_state == radio_status_pkg::sleep_state) ||
		(radio_fsm_state == radio_status_pkg::crystal_off_state);

	// The request stays up while select is low and the radio still
	// reports a low-power state, so the state machine may take it late.
	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			wake_to_idle_req <= 1'b0;
		end else begin
			// [R16] wake on select low
			wake_to_idle_req <= !chip_select_n && reported_asleep;
		end
	end

	// ----------------------------------------------------------------
	// Register read port
	// ----------------------------------------------------------------

	logic [DATA_W-1:0] next_rdata;
	logic [DATA_W-1:0] crc_result_status;
	logic [DATA_W-1:0] state_word;

	always_comb begin
		crc_result_status = '0;
		crc_result_status[`CRC_PASS_BIT] = crc_pass_flag;
	end

	always_comb begin
		state_word = '0;
		// [R6] code in low bits
		state_word[`STATE_CODE_MSB:`STATE_CODE_LSB] = radio_fsm_state;
	end

	always_comb begin
		case (reg_addr)
			`OFFSET_CARRIER_OFFSET_ESTIMATE: begin
				next_rdata = carrier_offset_estimate;
			end
			`OFFSET_CRC_RESULT_STATUS: begin
				next_rdata = crc_result_status;
			end
			`OFFSET_SIGNAL_STRENGTH: begin
				next_rdata = signal_strength;
			end
			`OFFSET_RADIO_FSM_STATE: begin
				next_rdata = state_word;
			end
			default: begin
				next_rdata = `UNMAPPED_READ_VALUE;
			end
		endcase
	end

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			reg_rdata <= `UNMAPPED_READ_VALUE;
			reg_rd_valid <= 1'b0;
		end else begin
			reg_rd_valid <= reg_rd_en;
			if (reg_rd_en) begin
				reg_rdata <= next_rdata;
			end
		end
	end

	// Write data is deliberately unused: every register here is status.
	logic unused_wdata;
	assign unused_wdata = ^reg_wdata;

	always_ff @(posedge core_clk) begin
		if (!rst_b) begin
			reg_wr_ignored <= 1'b0;
		end else begin
			// [R17] writes are dropped
			reg_wr_ignored <= reg_wr_en && !reg_rd_en;
		end
	end

endmodule
`default_nettype wire

// ---- test/radio_status_monitor.sv ----
// Port checker for the radio status read-back block.
// Assumes one clock domain; bound to every instance of the block.
`timescale 1ns/1ps
`default_nettype none
module radio_status_monitor (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic [5:0] reg_addr,
	input wire logic reg_rd_en,
	input wire logic reg_wr_en,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rd_valid,
	input wire logic reg_wr_ignored,
	input wire logic [1:0] modulation_select,
	input wire logic crc_check_done,
	input wire logic crc_check_match,
	input wire logic [4:0] fsm_state_code,
	input wire logic rx_mode_enter,
	input wire logic rx_mode_restart,
	input wire logic chip_select_n,
	input wire logic wake_to_idle_req,
	input wire logic state_code_fault,
	input wire logic crc_pass
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rst_b);
	a_read_answer: assert property (reg_rd_en |=> reg_rd_valid)
		else $error("read not answered");
	a_state_upper_zero: assert property (reg_rd_en && reg_addr == 6'h35 |=> reg_rdata[7:5] == 3'h0)
		else $error("state word upper bits set");
	a_crc_low_zero: assert property (reg_rd_en && reg_addr == 6'h33 |=> reg_rdata[6:0] == 7'h00)
		else $error("crc word low bits set");
	a_ook_reads_zero: assert property (reg_rd_en && reg_addr == 6'h32 && $past(modulation_select) == 2'h2 |=> reg_rdata == 8'h00)
		else $error("offset not zero under on-off keying");
	a_crc_result: assert property (crc_check_done |=> crc_pass == $past(crc_check_match))
		else $error("crc flag does not follow result");
	a_crc_clear: assert property ((rx_mode_enter || rx_mode_restart) && !crc_check_done |=> !crc_pass)
		else $error("crc flag not cleared");
	a_write_refused: assert property (reg_wr_en && !reg_rd_en |=> reg_wr_ignored)
		else $error("write not refused");
	a_bad_code_flag: assert property (fsm_state_code > 5'h16 |=> state_code_fault)
		else $error("undefined code not flagged");
	a_wake_cause: assert property (wake_to_idle_req |-> $past(!chip_select_n))
		else $error("wake without chip select");
	c_read: cover property (reg_rd_valid);
	c_crc_pass: cover property ($rose(crc_pass));
	c_wake: cover property (wake_to_idle_req);
endmodule
bind radio_status_readback radio_status_monitor u_monitor (.*);
`default_nettype wire

// ---- test/host_port_model.sv ----
// Host side of the register port: reads, writes and chip select.
// Assumes the block answers one cycle after a request.
`timescale 1ns/1ps
`default_nettype none
module host_port_model (
	input wire logic core_clk,
	input wire logic [7:0] reg_rdata,
	input wire logic reg_rd_valid,
	input wire logic reg_wr_ignored,
	output logic [5:0] reg_addr,
	output logic reg_rd_en,
	output logic reg_wr_en,
	output logic [7:0] reg_wdata,
	output logic chip_select_n
);
	initial begin
		reg_addr = 6'h00;
		reg_rd_en = 1'b0;
		reg_wr_en = 1'b0;
		reg_wdata = 8'h00;
		chip_select_n = 1'b1;
	end
	task automatic sel(input logic v);
		chip_select_n = v;
	endtask
	// Address and data are scrambled after use so no stale value leaks.
	task automatic acc(input logic w, input logic [5:0] a,
		input logic [7:0] wd, output logic [7:0] d, output logic f);
		@(negedge core_clk);
		reg_addr = a;
		reg_wdata = wd;
		reg_rd_en = !w;
		reg_wr_en = w;
		@(negedge core_clk);
		f = w ? reg_wr_ignored : reg_rd_valid;
		d = reg_rdata;
		reg_rd_en = 1'b0;
		reg_wr_en = 1'b0;
		reg_addr = ~a;
		reg_wdata = ~wd;
	endtask
endmodule
`default_nettype wire

// ---- test/testbench.sv ----
// Self-checking bench for the radio status read-back block.
// Assumes the host model and the checker bound to the block.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic core_clk, rst_b, reg_rd_en, reg_wr_en, reg_rd_valid;
	logic reg_wr_ignored, offset_estimate_valid, signal_strength_valid;
	logic crc_check_done, crc_check_match, rx_mode_enter, rx_mode_restart;
	logic chip_select_n, wake_to_idle_req, state_code_fault, crc_pass, f;
	logic [5:0] reg_addr;
	logic [7:0] reg_wdata, reg_rdata, offset_estimate_field;
	logic [7:0] signal_strength_value, d;
	logic [1:0] modulation_select;
	logic [4:0] fsm_state_code;
	int num_errors = 0;
	int compares = 0;
	radio_status_readback u_dut (.*);
	host_port_model u_host (.*);
	initial core_clk = 1'b0;
	always #4 core_clk = ~core_clk;
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic rdc(input logic [5:0] a, input logic [7:0] exp);
		u_host.acc(1'b0, a, 8'h00, d, f);
		chk(d, exp);
		chk({7'h00, f}, 8'h01);
	endtask
	task automatic strobe(ref logic s);
		s = 1'b1;
		@(negedge core_clk);
		s = 1'b0;
	endtask
	task automatic report_and_stop;
		$display("errors %0d compares %0d", num_errors, compares);
		if (num_errors == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		{rst_b, offset_estimate_valid, signal_strength_valid} = 3'h0;
		{crc_check_done, crc_check_match, rx_mode_enter} = 3'h0;
		rx_mode_restart = 1'b0;
		offset_estimate_field = 8'h00;
		signal_strength_value = 8'h00;
		modulation_select = 2'h0;
		fsm_state_code = 5'h01;
		repeat (8) @(negedge core_clk);
		rst_b = 1'b1;
		rdc(6'h35, 8'h01);
		rdc(6'h33, 8'h00);
		rdc(6'h36, 8'h00);
		for (int i = 0; i < 23; i++) begin
			fsm_state_code = i[4:0];
			rdc(6'h35, {3'h0, i[4:0]});
		end
		fsm_state_code = 5'h1F;
		rdc(6'h35, 8'h16);
		chk({7'h00, state_code_fault}, 8'h01);
		fsm_state_code = 5'h00;
		u_host.sel(1'b0);
		repeat (2) @(negedge core_clk);
		chk({7'h00, wake_to_idle_req}, 8'h01);
		u_host.sel(1'b1);
		fsm_state_code = 5'h01;
		for (int m = 0; m < 4; m++) begin
			modulation_select = m[1:0];
			offset_estimate_field = 8'hF0 + m[7:0];
			strobe(offset_estimate_valid);
			rdc(6'h32, m == 2 ? 8'h00 : 8'hF0 + m[7:0]);
		end
		signal_strength_value = 8'h7E;
		strobe(signal_strength_valid);
		rdc(6'h34, 8'h7E);
		for (int a = 50; a < 54; a++) begin
			u_host.acc(1'b1, a[5:0], 8'hFF, d, f);
			chk({7'h00, f}, 8'h01);
		end
		rdc(6'h34, 8'h7E);
		rdc(6'h35, 8'h01);
		crc_check_match = 1'b1;
		for (int j = 0; j < 2; j++) begin
			strobe(crc_check_done);
			rdc(6'h33, 8'h80);
			chk({7'h00, crc_pass}, 8'h01);
			if (j == 0)
				strobe(rx_mode_enter);
			else
				strobe(rx_mode_restart);
			rdc(6'h33, 8'h00);
		end
		report_and_stop();
	end
endmodule
`default_nettype wire
